// ### fps_cfg.svh
// Timing constants and register map for the fault protection supervisor.
// Assumes a 20 MHz system clock; included by the design and the testbench.
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

`define FPS_CLK_MHZ 20
// Filter times in ns, the typical figures
`define FPS_OT_FILT_NS 5000
`define FPS_BAT_FILT_NS 3500
`define FPS_CP_FILT_NS 4000
`define FPS_OT_FILT_CYC ((`FPS_OT_FILT_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_BAT_FILT_CYC ((`FPS_BAT_FILT_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_CP_FILT_CYC ((`FPS_CP_FILT_NS * `FPS_CLK_MHZ + 999) / 1000)
// Fail mode retry period in ms
`define FPS_RETRY_MS 64
`define FPS_RETRY_CYC (`FPS_RETRY_MS * 1000 * `FPS_CLK_MHZ)

// Register byte offsets
`define FPS_QUICK_STAT_OFS 12'h000
`define FPS_CH_STAT_OFS 12'h004
`define FPS_DEV_STAT_OFS 12'h008
`define FPS_OUT_CTRL_OFS 12'h00C
`define FPS_CH_CTRL_OFS 12'h010
`define FPS_MODE_OFS 12'h014

// Field positions
`define FPS_QS_OT_LSB 0
`define FPS_QS_PUMP_BIT 4
`define FPS_SUMMARY_BIT 31
`define FPS_DS_LOWBAT_BIT 0
`define FPS_DS_HIGHBAT_BIT 1
`define FPS_DS_LD_BIT 2
`define FPS_DS_CPOK_BIT 3
`define FPS_MODE_FAIL_BIT 0

`define FPS_OUT_CTRL_RST 4'h0
`define FPS_MODE_RST 1'b0

`endif

// ### fps_pkg.sv
// Types shared by the fault protection supervisor.
// Assumes fps_cfg.svh supplies the numbers.
package fps_pkg;

   // Raw analog comparator conditions
   typedef struct packed {
      logic [3:0] overTemp;
      logic lowBattery;
      logic highBattery;
      logic loadDump;
      logic pumpBad;
   } fps_raw_t;

   typedef enum logic [1:0] {
      FPS_RUN,
      FPS_FAULT_OFF,
      FPS_WAIT_RETRY
   } fps_bat_state_t;

endpackage : fps_pkg

// ### fps_supervisor.sv
// Digital fault supervisor of a quad high-side switch: filters fault
// conditions except load dump, gates the outputs, latches flags readable over APB.
// Assumes raw fault inputs come straight from analog comparators.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "fps_cfg.svh"

module fps_supervisor #(
   parameter int RETRY_CYC = `FPS_RETRY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Raw fault conditions from the analog side
   input wire fps_pkg::fps_raw_t rawFault,
   // Power stage
   output logic [3:0] outEnable,
   output logic [3:0] inrushRestart
);

   // ==========================================================
   // Input synchronisers
   logic [7:0] syncA_reg;
   logic [7:0] syncB_reg;
   logic [7:0] syncC_reg;
   logic [7:0] condStable_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_reg <= 8'h00;
         syncB_reg <= 8'h00;
         syncC_reg <= 8'h00;
         condStable_reg <= 8'h00;
      end else begin
         syncA_reg <= rawFault;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
         // A change counts once the second and third stages agree
         if (syncB_reg == syncC_reg) begin
            condStable_reg <= syncC_reg;
         end
      end
   end

   fps_pkg::fps_raw_t cond;
   assign cond = condStable_reg;

   // ==========================================================
   // Fault filters
   logic [3:0] otFilt;
   logic uvFilt;
   logic ovFilt;
   logic cpFilt;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_otFilt
         logic [7:0] cnt_reg;
         always_ff @(posedge clk) begin
            if (srst || !cond.overTemp[gi]) begin
               cnt_reg <= 8'h00;
            end else if (cnt_reg != 8'(`FPS_OT_FILT_CYC)) begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
         assign otFilt[gi] = (cnt_reg == 8'(`FPS_OT_FILT_CYC));
      end
   endgenerate

   logic [7:0] uvCnt_reg;
   logic [7:0] ovCnt_reg;
   logic [7:0] cpCnt_reg;
   always_ff @(posedge clk) begin
      if (srst || !cond.lowBattery) begin
         uvCnt_reg <= 8'h00;
      end else if (uvCnt_reg != 8'(`FPS_BAT_FILT_CYC)) begin
         uvCnt_reg <= uvCnt_reg + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (srst || !cond.highBattery) begin
         ovCnt_reg <= 8'h00;
      end else if (ovCnt_reg != 8'(`FPS_BAT_FILT_CYC)) begin
         ovCnt_reg <= ovCnt_reg + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (srst || !cond.pumpBad) begin
         cpCnt_reg <= 8'h00;
      end else if (cpCnt_reg != 8'(`FPS_CP_FILT_CYC)) begin
         cpCnt_reg <= cpCnt_reg + 8'h01;
      end
   end
   assign uvFilt = (uvCnt_reg == 8'(`FPS_BAT_FILT_CYC));
   assign ovFilt = (ovCnt_reg == 8'(`FPS_BAT_FILT_CYC));
   assign cpFilt = (cpCnt_reg == 8'(`FPS_CP_FILT_CYC));

   // ==========================================================
   // APB decode
   logic apbWr;
   logic apbRd;
   assign apbWr = psel && penable && pwrite && pready;
   assign apbRd = psel && penable && !pwrite && pready;

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   logic mapped;
   assign mapped = hit(paddr, `FPS_QUICK_STAT_OFS) || hit(paddr, `FPS_CH_STAT_OFS)
      || hit(paddr, `FPS_DEV_STAT_OFS) || hit(paddr, `FPS_OUT_CTRL_OFS)
      || hit(paddr, `FPS_CH_CTRL_OFS) || hit(paddr, `FPS_MODE_OFS);

   // Host on-write: output control writes all four, channel control sets
   logic [3:0] onWrite;
   logic [3:0] onWriteBits;
   always_comb begin
      onWrite = 4'h0;
      onWriteBits = 4'h0;
      if (apbWr && hit(paddr, `FPS_OUT_CTRL_OFS)) begin
         onWrite = 4'hF;
         onWriteBits = pwdata[3:0];
      end else if (apbWr && hit(paddr, `FPS_CH_CTRL_OFS)) begin
         onWrite = pwdata[3:0];
         onWriteBits = pwdata[3:0];
      end
   end

   // ==========================================================
   // Mode register
   logic failMode_reg;
   logic modeChange;
   assign modeChange = apbWr && hit(paddr, `FPS_MODE_OFS)
      && (pwdata[`FPS_MODE_FAIL_BIT] != failMode_reg);
   always_ff @(posedge clk) begin
      if (srst) begin
         failMode_reg <= `FPS_MODE_RST;
      end else if (apbWr && hit(paddr, `FPS_MODE_OFS)) begin
         failMode_reg <= pwdata[`FPS_MODE_FAIL_BIT];
      end
   end

   // ==========================================================
   // Output command, held across pump faults
   logic [3:0] onCmd_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         onCmd_reg <= `FPS_OUT_CTRL_RST;
      end else begin
         // Commands taken even while the pump is bad, run once valid
         for (int i = 0; i < 4; i++) begin
            if (onWrite[i]) begin
               onCmd_reg[i] <= onWriteBits[i];
            end
         end
      end
   end

   // ==========================================================
   // Overtemperature shutdown latch per channel
   logic [3:0] otOff_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         otOff_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (otFilt[i]) begin
               otOff_reg[i] <= 1'b1;
            end else if (failMode_reg && modeChange) begin
               otOff_reg[i] <= 1'b0;
            end else if (!failMode_reg && onWrite[i] && onWriteBits[i]
                         && !cond.overTemp[i]) begin
               otOff_reg[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Battery undervoltage shutdown and fail mode retry
   fps_pkg::fps_bat_state_t batState_reg;
   logic [20:0] retryCnt_reg;
   logic batOff;
   assign batOff = (batState_reg != fps_pkg::FPS_RUN);
   always_ff @(posedge clk) begin
      if (srst) begin
         batState_reg <= fps_pkg::FPS_RUN;
         retryCnt_reg <= 21'h000000;
      end else begin
         case (batState_reg)
            fps_pkg::FPS_RUN: begin
               if (uvFilt) begin
                  batState_reg <= fps_pkg::FPS_FAULT_OFF;
               end
            end
            fps_pkg::FPS_FAULT_OFF: begin
               retryCnt_reg <= 21'h000000;
               if (failMode_reg) begin
                  batState_reg <= fps_pkg::FPS_WAIT_RETRY;
               end else if (!cond.lowBattery && (|(onWrite & onWriteBits))) begin
                  batState_reg <= fps_pkg::FPS_RUN;
               end
            end
            fps_pkg::FPS_WAIT_RETRY: begin
               if (!failMode_reg) begin
                  batState_reg <= fps_pkg::FPS_FAULT_OFF;
               end else if (retryCnt_reg >= 21'(RETRY_CYC - 1)) begin
                  retryCnt_reg <= 21'h000000;
                  // Retry only once the battery has recovered
                  if (!cond.lowBattery) begin
                     batState_reg <= fps_pkg::FPS_RUN;
                  end
               end else begin
                  retryCnt_reg <= retryCnt_reg + 21'h000001;
               end
            end
            default: begin
               batState_reg <= fps_pkg::FPS_RUN;
            end
         endcase
      end
   end

   // ==========================================================
   // Output gating
   logic allOff;
   assign allOff = batOff || cpFilt || cond.pumpBad || cond.loadDump;
   logic [3:0] outNext;
   assign outNext = allOff ? 4'h0 : (onCmd_reg & ~otOff_reg & ~otFilt);
   always_ff @(posedge clk) begin
      if (srst) begin
         outEnable <= 4'h0;
         inrushRestart <= 4'h0;
      end else begin
         outEnable <= outNext;
         // Each fresh turn-on restarts the inrush current window
         inrushRestart <= outNext & ~outEnable;
      end
   end

   // ==========================================================
   // Latched diagnosis flags
   logic [3:0] otFlag_reg;
   logic uvFlag_reg;
   logic ovFlag_reg;
   logic ldFlag_reg;
   logic cpFlag_reg;
   logic rdQuick;
   logic rdChan;
   logic rdDev;
   assign rdQuick = apbRd && hit(paddr, `FPS_QUICK_STAT_OFS);
   assign rdChan = apbRd && hit(paddr, `FPS_CH_STAT_OFS);
   assign rdDev = apbRd && hit(paddr, `FPS_DEV_STAT_OFS);

   // Set wins over a clearing read in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         otFlag_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (otFilt[i]) begin
               otFlag_reg[i] <= 1'b1;
            end else if (rdChan && !cond.overTemp[i]) begin
               otFlag_reg[i] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         uvFlag_reg <= 1'b0;
      end else if (uvFilt) begin
         uvFlag_reg <= 1'b1;
      end else if (rdDev && !cond.lowBattery) begin
         uvFlag_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ovFlag_reg <= 1'b0;
      end else if (ovFilt) begin
         ovFlag_reg <= 1'b1;
      end else if (rdDev && !cond.highBattery) begin
         ovFlag_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ldFlag_reg <= 1'b0;
      end else if (cond.loadDump) begin
         ldFlag_reg <= 1'b1;
      end else if (rdDev) begin
         ldFlag_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cpFlag_reg <= 1'b0;
      end else if (cpFilt) begin
         cpFlag_reg <= 1'b1;
      end else if (rdQuick && !cond.pumpBad) begin
         cpFlag_reg <= 1'b0;
      end
   end

   logic summary;
   assign summary = uvFlag_reg || ovFlag_reg || cpFlag_reg;

   // ==========================================================
   // APB read data and handshake: one wait state, answer in access+1
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h00000000;
      if (hit(paddr, `FPS_QUICK_STAT_OFS)) begin
         rdata[`FPS_QS_OT_LSB +: 4] = otFlag_reg;
         rdata[`FPS_QS_PUMP_BIT] = cpFlag_reg;
      end else if (hit(paddr, `FPS_CH_STAT_OFS)) begin
         rdata[3:0] = otFlag_reg;
      end else if (hit(paddr, `FPS_DEV_STAT_OFS)) begin
         rdata[`FPS_DS_LOWBAT_BIT] = uvFlag_reg;
         rdata[`FPS_DS_HIGHBAT_BIT] = ovFlag_reg;
         rdata[`FPS_DS_LD_BIT] = ldFlag_reg;
         rdata[`FPS_DS_CPOK_BIT] = !cond.pumpBad;
      end else if (hit(paddr, `FPS_OUT_CTRL_OFS) || hit(paddr, `FPS_CH_CTRL_OFS)) begin
         rdata[3:0] = onCmd_reg;
         rdata[7:4] = outEnable;
      end else if (hit(paddr, `FPS_MODE_OFS)) begin
         rdata[`FPS_MODE_FAIL_BIT] = failMode_reg;
      end
      rdata[`FPS_SUMMARY_BIT] = summary && mapped;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h00000000 : rdata;
            pslverr <= !mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule : fps_supervisor

// ### fps_supervisor_sva.sv
// Port checker for the fault protection supervisor.
// Assumes it is bound onto fps_supervisor and sees only its ports.
`timescale 1ns/1ps
module fps_supervisor_sva #(
   parameter int RETRY_CYC = 200
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Analog side and power stage
   input wire fps_pkg::fps_raw_t rawFault,
   input wire logic [3:0] outEnable,
   input wire logic [3:0] inrushRestart
);
   logic [7:0] otCnt;
   logic [7:0] uvCnt;
   logic [7:0] ovCnt;
   logic [7:0] cpCnt;
   logic rdAck;

   // ====================
   // Run lengths of raw conditions
   function automatic logic [7:0] runLen(input logic [7:0] c, input logic on);
      return on ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
   endfunction : runLen

   // Saturating, so a long fault keeps its antecedent true
   always_ff @(posedge clk) begin
      if (srst) begin
         otCnt <= 8'h00;
         uvCnt <= 8'h00;
         ovCnt <= 8'h00;
         cpCnt <= 8'h00;
      end else begin
         otCnt <= runLen(otCnt, rawFault.overTemp[0]);
         uvCnt <= runLen(uvCnt, rawFault.lowBattery);
         ovCnt <= runLen(ovCnt, rawFault.highBattery);
         cpCnt <= runLen(cpCnt, rawFault.pumpBad);
      end
   end

   assign rdAck = pready && !pwrite;

   // ====================
   // Properties; margins cover the input synchroniser
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_ot_chan_off: assert property (otCnt >= 8'h6E |-> !outEnable[0])
      else $error("overtemp channel still on");
   chk_ot_reported: assert property (rdAck && paddr <= 12'h004 && otCnt >= 8'h6E |-> prdata[0])
      else $error("overtemp flag missing");
   chk_uv_all_off: assert property (uvCnt >= 8'h50 |-> outEnable == 4'h0)
      else $error("outputs on in undervoltage");
   chk_uv_flags: assert property (rdAck && paddr == 12'h008 && uvCnt >= 8'h50 |-> prdata[0] && prdata[31])
      else $error("undervoltage flags missing");
   chk_ov_flags: assert property (rdAck && paddr == 12'h008 && ovCnt >= 8'h50 |-> prdata[1] && prdata[31])
      else $error("overvoltage flags missing");
   chk_ld_dark: assert property (rawFault.loadDump [*6] |-> outEnable == 4'h0)
      else $error("outputs on in load dump");
   chk_cp_all_off: assert property (cpCnt >= 8'h5A |-> outEnable == 4'h0)
      else $error("outputs on with pump fault");
   chk_cp_flags: assert property (rdAck && paddr == 12'h000 && cpCnt >= 8'h5A |-> prdata[4] && prdata[31])
      else $error("pump fault flags missing");
   chk_inrush_pulse: assert property (inrushRestart[0] |=> !inrushRestart[0])
      else $error("inrush restart not a pulse");

   cov_uv: cover property (uvCnt == 8'h50);
   cov_inrush: cover property (inrushRestart != 4'h0);
   cov_slverr: cover property (pready && pslverr);
endmodule : fps_supervisor_sva

bind fps_supervisor fps_supervisor_sva #(.RETRY_CYC(RETRY_CYC)) chk (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rawFault(rawFault), .outEnable(outEnable), .inrushRestart(inrushRestart)
);

// ### fps_host_model.sv
// Host controller model: an APB master issuing register accesses.
// Assumes one slave that answers with pready after a wait.
`timescale 1ns/1ps
module fps_host_model (
   // Clock
   input wire logic clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // ====================
   // One transfer; no fixed latency is assumed
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so stale values never look valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : fps_host_model

// ### fps_supervisor_tb_top.sv
// Self-checking bench for the fault protection supervisor.
// Assumes the host model drives APB and the checker is bound in.
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_supervisor_tb_top;
   localparam int RETRY = 200;
   logic clk;
   logic srst;
   fps_pkg::fps_raw_t raw;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] outEnable;
   logic [3:0] inrushRestart;
   logic [31:0] q;
   logic err;
   logic [3:0] seen;
   int mismatches;
   int total_checks;

   fps_supervisor #(.RETRY_CYC(RETRY)) uut (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rawFault(raw), .outEnable(outEnable),
      .inrushRestart(inrushRestart)
   );
   fps_host_model host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   always #25 clk = ~clk;

   // ====================
   // Shared helpers
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, err);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      host.xfer(1'b0, a, 32'h0, q, err);
   endtask : rd
   task automatic chkOut(input logic [3:0] exp);
      check("outEnable", 32'(outEnable), 32'(exp));
   endtask : chkOut
   task automatic waitOut(input logic [3:0] exp, input int lim);
      seen = 4'h0;
      for (int i = 0; i < lim && outEnable !== exp; i++) begin
         @(posedge clk);
         seen = seen | inrushRestart;
      end
   endtask : waitOut

   // ====================
   // Scenarios
   task automatic t_pwrup;
      wr(`FPS_OUT_CTRL_OFS, 32'hF);
      cyc(4);
      chkOut(4'h0);
      raw.pumpBad <= 1'b0;
      waitOut(4'hF, 40);
      chkOut(4'hF);
      host.xfer(1'b0, 12'h100, 32'h0, q, err);
      check("pslverr", 32'(err), 32'h1);
      check("prdata", q, 32'h0);
      rd(`FPS_QUICK_STAT_OFS);
      rd(`FPS_QUICK_STAT_OFS);
      check("quick", q & 32'h10, 32'h0);
      $display("TB test pwrup done");
   endtask : t_pwrup

   task automatic t_ot;
      raw.overTemp[0] <= 1'b1;
      cyc(60);
      raw.overTemp[0] <= 1'b0;
      cyc(60);
      chkOut(4'hF);
      raw.overTemp[0] <= 1'b1;
      cyc(120);
      chkOut(4'hE);
      rd(`FPS_QUICK_STAT_OFS);
      check("quick", q & 32'h1, 32'h1);
      rd(`FPS_CH_STAT_OFS);
      raw.overTemp[0] <= 1'b0;
      cyc(8);
      wr(`FPS_CH_CTRL_OFS, 32'h2);
      cyc(4);
      chkOut(4'hE);
      rd(`FPS_CH_STAT_OFS);
      check("chan", q & 32'h1, 32'h1);
      rd(`FPS_CH_STAT_OFS);
      check("chan", q & 32'h1, 32'h0);
      wr(`FPS_CH_CTRL_OFS, 32'h1);
      cyc(4);
      chkOut(4'hF);
      $display("TB test ot done");
   endtask : t_ot

   task automatic t_batt;
      raw.lowBattery <= 1'b1;
      cyc(90);
      chkOut(4'h0);
      rd(`FPS_DEV_STAT_OFS);
      check("dev", q & 32'h80000001, 32'h80000001);
      wr(`FPS_OUT_CTRL_OFS, 32'hF);
      cyc(4);
      chkOut(4'h0);
      raw.lowBattery <= 1'b0;
      raw.highBattery <= 1'b1;
      cyc(90);
      rd(`FPS_DEV_STAT_OFS);
      check("dev", q & 32'h80000003, 32'h80000003);
      raw.highBattery <= 1'b0;
      cyc(8);
      rd(`FPS_DEV_STAT_OFS);
      // The previous read came after undervoltage had gone, so only overvoltage stays
      check("dev", q & 32'h3, 32'h2);
      rd(`FPS_DEV_STAT_OFS);
      check("dev", q & 32'h80000003, 32'h0);
      wr(`FPS_OUT_CTRL_OFS, 32'hF);
      cyc(4);
      chkOut(4'hF);
      raw.loadDump <= 1'b1;
      cyc(10);
      chkOut(4'h0);
      raw.loadDump <= 1'b0;
      cyc(8);
      rd(`FPS_DEV_STAT_OFS);
      check("dev", q & 32'hC, 32'hC);
      $display("TB test battery done");
   endtask : t_batt

   task automatic t_pump;
      raw.pumpBad <= 1'b1;
      cyc(100);
      chkOut(4'h0);
      rd(`FPS_QUICK_STAT_OFS);
      check("quick", q & 32'h80000010, 32'h80000010);
      wr(`FPS_OUT_CTRL_OFS, 32'h5);
      raw.pumpBad <= 1'b0;
      waitOut(4'h5, 30);
      chkOut(4'h5);
      check("inrush", 32'(seen), 32'h5);
      rd(`FPS_QUICK_STAT_OFS);
      check("quick", q & 32'h10, 32'h10);
      rd(`FPS_QUICK_STAT_OFS);
      check("quick", q & 32'h80000010, 32'h0);
      $display("TB test pump done");
   endtask : t_pump

   task automatic t_fail;
      wr(`FPS_OUT_CTRL_OFS, 32'hF);
      wr(`FPS_MODE_OFS, 32'h1);
      raw.overTemp[1] <= 1'b1;
      cyc(120);
      raw.overTemp[1] <= 1'b0;
      cyc(8);
      wr(`FPS_CH_CTRL_OFS, 32'h2);
      cyc(4);
      chkOut(4'hD);
      wr(`FPS_MODE_OFS, 32'h0);
      cyc(4);
      chkOut(4'hF);
      rd(`FPS_CH_STAT_OFS);
      wr(`FPS_MODE_OFS, 32'h1);
      raw.lowBattery <= 1'b1;
      cyc(90);
      raw.lowBattery <= 1'b0;
      cyc(10);
      chkOut(4'h0);
      // Still well inside the retry period: no early restart
      cyc(100);
      chkOut(4'h0);
      // No host write here: only the retry timer may restart
      waitOut(4'hF, RETRY + 40);
      chkOut(4'hF);
      $display("TB test fail mode done");
   endtask : t_fail

   task automatic test_done;
      $display("TB checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // ====================
   // Main sequence and watchdog
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      raw = 8'h01;
      mismatches = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_pwrup();
      t_ot();
      t_batt();
      t_pump();
      t_fail();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule : fps_supervisor_tb_top
